// ### hw/aehsf_mailbox.sv
// mailbox status flags: host view and firmware view of one status byte,
// plus the data bytes whose accesses move the handshake flags, and the byte control that picks the last byte
// assumes one access per port per cycle, strobes one cycle wide, synchronous to clk_sys
`timescale 1ns/10ps
module aehsf_mailbox
   import aehsf_pkg::*;
#(
   parameter int NUM_BYTES = AEHSF_NUM_BYTES
)
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // host register port
   input  wire logic [2:0] hostAddr,
   input  wire logic       hostWrEn,
   input  wire logic       hostRdEn,
   input  wire logic [7:0] hostWrData,
   output logic      [7:0] hostRdData_r,
   // firmware register port
   input  wire logic [2:0] fwAddr,
   input  wire logic       fwWrEn,
   input  wire logic       fwRdEn,
   input  wire logic [7:0] fwWrData,
   output logic      [7:0] fwRdData_r,
   // live status byte
   output logic      [7:0] statusByte_r
);
   import aehsf_pkg::*;

   // the two-bit byte index below only serves four data bytes
   if (NUM_BYTES != AEHSF_NUM_BYTES) begin : g_bad_num_bytes
      $error("aehsf_mailbox: only four data bytes are supported");
   end

   // the byte that completes a transfer depends on the access width mode
   function automatic logic isLastByte(input logic [2:0] addr, input logic fourByte);
      isLastByte = (addr == (fourByte ? AEHSF_OFS_DATA3 : AEHSF_OFS_DATA0));
   endfunction : isLastByte

   function automatic logic isData(input logic [2:0] addr);
      isData = (addr <= AEHSF_OFS_DATA3);
   endfunction : isData

   // host writes to bytes 1 to 3 are dropped and host reads of them return zero in single-byte mode
   function automatic logic isLiveByte(input logic [2:0] addr, input logic fourByte);
      isLiveByte = fourByte || (addr == AEHSF_OFS_DATA0);
   endfunction : isLiveByte

   function automatic logic isStatus(input logic [2:0] addr);
      isStatus = (addr == AEHSF_OFS_STATUS);
   endfunction : isStatus

   function automatic logic isByteCtl(input logic [2:0] addr);
      isByteCtl = (addr == AEHSF_OFS_BYTECTL);
   endfunction : isByteCtl

   logic [7:0] os2ec_r [NUM_BYTES];
   logic [7:0] os2ec_nxt [NUM_BYTES];
   logic [7:0] ec2os_r [NUM_BYTES];
   logic [7:0] ec2os_nxt [NUM_BYTES];
   logic       fourByte_r;
   logic       fourByte_nxt;
   logic [7:0] hostRdData_nxt;
   logic [7:0] fwRdData_nxt;

   // decoded accesses and the flag events they raise
   logic       hostCmdWr;
   logic       hostDataWr;
   logic       hostDataRd;
   logic       fwDataWr;
   logic       fwDataRd;
   logic       fwStatusWr;
   logic       cmdSet;
   logic       cmdClr;
   logic       ibfSet;
   logic       ibfClr;
   logic       obfSet;
   logic       obfClr;
   logic       cmdFlag;

   assign hostCmdWr  = hostWrEn && isStatus(hostAddr);
   assign hostDataWr = hostWrEn && isData(hostAddr);
   assign hostDataRd = hostRdEn && isData(hostAddr);
   assign fwDataWr   = fwWrEn && isData(fwAddr);
   assign fwDataRd   = fwRdEn && isData(fwAddr);
   assign fwStatusWr = fwWrEn && isStatus(fwAddr);
   assign cmdFlag    = statusByte_r[AEHSF_BIT_CMD];

   // handshake events
   // a set and a clear may meet in one cycle; the flag register lets the set win
   always_comb begin
      cmdSet = hostCmdWr;
      // any of the four data bytes clears it, whatever the width mode
      cmdClr = hostDataWr;
      ibfSet = hostCmdWr || (hostDataWr && isLastByte(hostAddr, fourByte_r));
      // with a command pending only byte 0 matters, width mode ignored
      if (cmdFlag) begin
         ibfClr = fwDataRd && (fwAddr == AEHSF_OFS_DATA0);
      end else begin
         ibfClr = fwDataRd && isLastByte(fwAddr, fourByte_r);
      end
      obfSet = fwDataWr && isLastByte(fwAddr, fourByte_r);
      obfClr = hostDataRd && isLastByte(hostAddr, fourByte_r);
   end

   // firmware writes reach only the soft bits; the handshake bits stay with hardware
   aehsf_status_reg u_status (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .fwWr     (fwStatusWr),
      .fwData   (fwWrData),
      .cmdSet   (cmdSet),
      .cmdClr   (cmdClr),
      .ibfSet   (ibfSet),
      .ibfClr   (ibfClr),
      .obfSet   (obfSet),
      .obfClr   (obfClr),
      .status_r (statusByte_r)
   );

   // data bytes
   always_comb begin
      for (int i = 0; i < NUM_BYTES; i++) begin
         os2ec_nxt[i] = os2ec_r[i];
         ec2os_nxt[i] = ec2os_r[i];
      end
      // a command lands in byte 0 of the inbound data
      if (hostCmdWr) begin
         os2ec_nxt[AEHSF_OFS_DATA0[1:0]] = hostWrData;
      end
      // upper bytes are dropped in single-byte mode
      if (hostDataWr && isLiveByte(hostAddr, fourByte_r)) begin
         os2ec_nxt[hostAddr[1:0]] = hostWrData;
      end
      // firmware fills all four outbound bytes in either mode
      if (fwDataWr) begin
         ec2os_nxt[fwAddr[1:0]] = fwWrData;
      end
   end

   // byte mode belongs to firmware; the host can only read it
   always_comb begin
      fourByte_nxt = fourByte_r;
      if (fwWrEn && isByteCtl(fwAddr)) begin
         fourByte_nxt = fwWrData[AEHSF_BIT_FOURBYTE];
      end
   end

   // registered read answers
   always_comb begin
      hostRdData_nxt = hostRdData_r;
      fwRdData_nxt   = fwRdData_r;
      if (hostRdEn) begin
         // reserved offsets and unregistered bytes read as zero
         hostRdData_nxt = AEHSF_ZERO_BYTE;
         if (isData(hostAddr)) begin
            if (isLiveByte(hostAddr, fourByte_r)) begin
               hostRdData_nxt = ec2os_r[hostAddr[1:0]];
            end
         end else if (isStatus(hostAddr)) begin
            // host gets a read-only view of the firmware's status byte
            hostRdData_nxt = statusByte_r;
         end else if (isByteCtl(hostAddr)) begin
            hostRdData_nxt[AEHSF_BIT_FOURBYTE] = fourByte_r;
         end
      end
      if (fwRdEn) begin
         fwRdData_nxt = AEHSF_ZERO_BYTE;
         if (isData(fwAddr)) begin
            fwRdData_nxt = os2ec_r[fwAddr[1:0]];
         end else if (isStatus(fwAddr)) begin
            // includes the command flag so firmware can spot a command start
            fwRdData_nxt = statusByte_r;
         end else if (isByteCtl(fwAddr)) begin
            fwRdData_nxt[AEHSF_BIT_FOURBYTE] = fourByte_r;
         end
      end
   end

   // one register pair per data byte
   for (genvar g = 0; g < NUM_BYTES; g++) begin : g_byte
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            os2ec_r[g] <= AEHSF_BYTE_RST;
            ec2os_r[g] <= AEHSF_BYTE_RST;
         end else begin
            os2ec_r[g] <= os2ec_nxt[g];
            ec2os_r[g] <= ec2os_nxt[g];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fourByte_r <= AEHSF_BYTE_RST[AEHSF_BIT_FOURBYTE];
      end else begin
         fourByte_r <= fourByte_nxt;
      end
   end

   // read answers hold until the next read on their own port
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hostRdData_r <= AEHSF_ZERO_BYTE;
         fwRdData_r   <= AEHSF_ZERO_BYTE;
      end else begin
         hostRdData_r <= hostRdData_nxt;
         fwRdData_r   <= fwRdData_nxt;
      end
   end
endmodule : aehsf_mailbox

// ### hw/aehsf_pkg.sv
// constants shared by the mailbox status flag block
// assumes host and firmware ports both address the block with 3-bit byte offsets
package aehsf_pkg;
   // register offsets, same on host and firmware ports
   localparam logic [2:0] AEHSF_OFS_DATA0   = 3'h0;
   localparam logic [2:0] AEHSF_OFS_DATA3   = 3'h3;
   localparam logic [2:0] AEHSF_OFS_STATUS  = 3'h4;
   localparam logic [2:0] AEHSF_OFS_BYTECTL = 3'h5;
   // status byte field positions
   localparam int AEHSF_BIT_OBF   = 0;
   localparam int AEHSF_BIT_IBF   = 1;
   localparam int AEHSF_BIT_UD2   = 2;
   localparam int AEHSF_BIT_CMD   = 3;
   localparam int AEHSF_BIT_BURST = 4;
   localparam int AEHSF_BIT_SCI   = 5;
   localparam int AEHSF_BIT_SMI   = 6;
   localparam int AEHSF_BIT_UD7   = 7;
   // byte control field position
   localparam int AEHSF_BIT_FOURBYTE = 0;
   // bits firmware may write in the status byte: 7, 6, 5, 4 and 2
   localparam logic [7:0] AEHSF_FW_WR_MASK = 8'hF4;
   localparam logic [7:0] AEHSF_STATUS_RST = 8'h00;
   localparam logic [7:0] AEHSF_BYTE_RST   = 8'h00;
   localparam logic [7:0] AEHSF_ZERO_BYTE  = 8'h00;
   localparam int         AEHSF_NUM_BYTES  = 4;
endpackage : aehsf_pkg

// ### hw/aehsf_status_reg.sv
// status byte storage: firmware flags plus hardware handshake flags
// assumes all event strobes are single-cycle and synchronous to clk_sys
`timescale 1ns/10ps
module aehsf_status_reg
   import aehsf_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // firmware write of the status byte
   input  wire logic       fwWr,
   input  wire logic [7:0] fwData,
   // hardware events
   input  wire logic       cmdSet,
   input  wire logic       cmdClr,
   input  wire logic       ibfSet,
   input  wire logic       ibfClr,
   input  wire logic       obfSet,
   input  wire logic       obfClr,
   // stored byte
   output logic      [7:0] status_r
);
   import aehsf_pkg::*;

   logic [7:0] status_nxt;

   always_comb begin
      status_nxt = status_r;
      // smi, sci, burst and user bits are plain storage with no side effect
      if (fwWr) begin
         status_nxt = (status_r & ~AEHSF_FW_WR_MASK) | (fwData & AEHSF_FW_WR_MASK);
      end
      // set beats clear so a host write landing with a clear is never lost
      if (cmdClr) begin
         status_nxt[AEHSF_BIT_CMD] = 1'b0;
      end
      if (cmdSet) begin
         status_nxt[AEHSF_BIT_CMD] = 1'b1;
      end
      if (ibfClr) begin
         status_nxt[AEHSF_BIT_IBF] = 1'b0;
      end
      if (ibfSet) begin
         status_nxt[AEHSF_BIT_IBF] = 1'b1;
      end
      if (obfClr) begin
         status_nxt[AEHSF_BIT_OBF] = 1'b0;
      end
      if (obfSet) begin
         status_nxt[AEHSF_BIT_OBF] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status_r <= AEHSF_STATUS_RST;
      end else begin
         status_r <= status_nxt;
      end
   end
endmodule : aehsf_status_reg

// ### tb/aehsf_host_model.sv
// host side of the mailbox: single-cycle reads and writes on the host port
// assumes the caller samples the answer when the task returns
`timescale 1ns/10ps
module aehsf_host_model (
   input  logic       clk_sys,
   output logic [2:0] hostAddr,
   output logic       hostWrEn,
   output logic       hostRdEn,
   output logic [7:0] hostWrData
);
   initial begin
      hostAddr = 3'h0;
      hostWrEn = 1'b0;
      hostRdEn = 1'b0;
      hostWrData = 8'h00;
   end
   task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      hostAddr = a;
      hostWrData = d;
      hostWrEn = wr;
      hostRdEn = !wr;
      @(negedge clk_sys);
      hostWrEn = 1'b0;
      hostRdEn = 1'b0;
      // released data must not look like a held value
      hostWrData = ~d;
   endtask : acc
endmodule : aehsf_host_model

// ### tb/aehsf_mailbox_tb.sv
// self-checking bench for the mailbox status flags
// assumes one-cycle answers on both ports
`timescale 1ns/10ps
module aehsf_mailbox_tb;
   import aehsf_pkg::*;
   logic       clk_sys, rst_n, hostWrEn, hostRdEn, fwWrEn, fwRdEn;
   logic [2:0] hostAddr, fwAddr;
   logic [7:0] hostWrData, fwWrData, hostRdData_r, fwRdData_r, statusByte_r;
   int bad_count = 0;
   int total_checks = 0;
   aehsf_host_model u_host (.clk_sys, .hostAddr, .hostWrEn, .hostRdEn, .hostWrData);
   aehsf_mailbox #(.NUM_BYTES(4)) DUT (.clk_sys, .rst_n, .hostAddr, .hostWrEn, .hostRdEn,
      .hostWrData, .hostRdData_r, .fwAddr, .fwWrEn, .fwRdEn, .fwWrData, .fwRdData_r,
      .statusByte_r);
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic fw(input logic wr, input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      fwAddr = a;
      fwWrData = d;
      fwWrEn = wr;
      fwRdEn = !wr;
      @(negedge clk_sys);
      fwWrEn = 1'b0;
      fwRdEn = 1'b0;
   endtask : fw
   task automatic t_cmd;
      u_host.acc(1'b1, 3'h4, 8'hA5);
      chk(statusByte_r, 8'h0A);
      fw(1'b0, 3'h4, 8'h00);
      chk(fwRdData_r, 8'h0A);
      fw(1'b0, 3'h0, 8'h00);
      chk(fwRdData_r, 8'hA5);
      chk(statusByte_r, 8'h08);
   endtask : t_cmd
   // every data byte drops the command flag, in both byte modes
   task automatic t_data;
      for (int m = 0; m < 2; m++) begin
         fw(1'b1, 3'h5, 8'(m));
         for (int i = 3; i >= 0; i--) begin
            u_host.acc(1'b1, 3'h4, 8'h3C);
            u_host.acc(1'b1, 3'(i), 8'h11);
            chk(statusByte_r & 8'h08, 8'h00);
         end
         fw(1'b0, (m == 1) ? 3'h3 : 3'h0, 8'h00);
         chk(statusByte_r, 8'h00);
      end
      fw(1'b1, 3'h5, 8'h00);
   endtask : t_data
   task automatic t_flags;
      fw(1'b1, 3'h4, 8'hFF);
      u_host.acc(1'b0, 3'h4, 8'h00);
      chk(hostRdData_r, 8'hF4);
      u_host.acc(1'b1, 3'h4, 8'h00);
      chk(statusByte_r, 8'hFE);
      fw(1'b1, 3'h4, 8'h20);
      chk(statusByte_r, 8'h2A);
      fw(1'b1, 3'h4, 8'h40);
      chk(statusByte_r, 8'h4A);
      fw(1'b0, 3'h0, 8'h00);
   endtask : t_flags
   task automatic t_obf;
      fw(1'b1, 3'h0, 8'h5A);
      chk(statusByte_r & 8'h01, 8'h01);
      u_host.acc(1'b0, 3'h1, 8'h00);
      chk(statusByte_r & 8'h01, 8'h01);
      u_host.acc(1'b0, 3'h0, 8'h00);
      chk(hostRdData_r, 8'h5A);
      chk(statusByte_r & 8'h01, 8'h00);
      fw(1'b1, 3'h5, 8'h01);
      u_host.acc(1'b0, 3'h5, 8'h00);
      chk(hostRdData_r, 8'h01);
      fw(1'b1, 3'h0, 8'h00);
      chk(statusByte_r & 8'h01, 8'h00);
      fw(1'b1, 3'h3, 8'h00);
      chk(statusByte_r & 8'h01, 8'h01);
      u_host.acc(1'b0, 3'h3, 8'h00);
      chk(statusByte_r & 8'h01, 8'h00);
   endtask : t_obf
   // reset in mid-run clears the flags and drops back to single-byte mode
   task automatic t_reset;
      @(negedge clk_sys);
      rst_n = 1'b0;
      @(negedge clk_sys);
      rst_n = 1'b1;
      chk(statusByte_r, 8'h00);
      fw(1'b1, 3'h0, 8'h00);
      chk(statusByte_r, 8'h01);
   endtask : t_reset
   task automatic tally_and_finish;
      if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   initial begin
      rst_n = 1'b0;
      fwAddr = 3'h0;
      fwWrData = 8'h00;
      fwWrEn = 1'b0;
      fwRdEn = 1'b0;
      repeat (12) @(negedge clk_sys);
      rst_n = 1'b1;
      chk(statusByte_r, 8'h00);
      t_cmd;
      t_data;
      t_flags;
      t_obf;
      t_reset;
      tally_and_finish;
   end
endmodule : aehsf_mailbox_tb

// ### tb/aehsf_properties.sv
// assertions on the mailbox status byte, seen at the top ports only
// assumes single-cycle strobes on both ports and a synchronous reset
`timescale 1ns/10ps
module aehsf_properties #(
   parameter int NUM_BYTES = 4
) (
   // clock and reset
   input logic       clk_sys,
   input logic       rst_n,
   // host register port
   input logic       hostWrEn,
   input logic       hostRdEn,
   input logic [2:0] hostAddr,
   input logic [7:0] hostRdData_r,
   // firmware register port
   input logic       fwWrEn,
   input logic       fwRdEn,
   input logic [2:0] fwAddr,
   input logic [7:0] fwWrData,
   input logic [7:0] fwRdData_r,
   // live status byte
   input logic [7:0] statusByte_r
);
   logic fourByte_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // private copy of the byte mode, so the last byte can be told apart
   always_ff @(posedge clk_sys)
      if (!rst_n) fourByte_r <= 1'b0;
      else if (fwWrEn && fwAddr == 3'h5) fourByte_r <= fwWrData[0];
   sequence cmdWr; hostWrEn && hostAddr == 3'h4; endsequence
   sequence cmdSeen; statusByte_r[3] && statusByte_r[1]; endsequence
   cmd_flag_set_a: assert property (cmdWr |=> cmdSeen) else $error("cmd flags");
   cmd_flag_clr_a: assert property (hostWrEn && hostAddr < 3'(NUM_BYTES) |=> !statusByte_r[3])
      else $error("cmd clear");
   host_view_a: assert property (hostRdEn && hostAddr == 3'h4
      |=> hostRdData_r == $past(statusByte_r)) else $error("host view");
   fw_view_a: assert property (fwRdEn && fwAddr == 3'h4
      |=> fwRdData_r == $past(statusByte_r)) else $error("fw view");
   fw_flags_a: assert property (fwWrEn && fwAddr == 3'h4
      |=> (statusByte_r & 8'hF4) == ($past(fwWrData) & 8'hF4)) else $error("fw flags");
   soft_hold_a: assert property (!(fwWrEn && fwAddr == 3'h4)
      |=> $stable(statusByte_r & 8'hF4)) else $error("soft flags moved");
   ibf_clear_a: assert property (fwRdEn && fwAddr == 3'h0 && statusByte_r[3]
      && !hostWrEn |=> !statusByte_r[1]) else $error("ibf clear");
   obf_set_a: assert property (fwWrEn && fwAddr == (fourByte_r ? 3'h3 : 3'h0)
      |=> statusByte_r[0]) else $error("obf set");
   ibf_set_a: assert property (hostWrEn && hostAddr == (fourByte_r ? 3'h3 : 3'h0)
      |=> statusByte_r[1]) else $error("ibf set");
   obf_clear_a: assert property (hostRdEn && hostAddr == (fourByte_r ? 3'h3 : 3'h0)
      && !(fwWrEn && fwAddr == (fourByte_r ? 3'h3 : 3'h0)) |=> !statusByte_r[0])
      else $error("obf clear");
   reset_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0)
      !rst_n |=> statusByte_r == 8'h00) else $error("reset value");
endmodule : aehsf_properties

bind aehsf_mailbox aehsf_properties #(.NUM_BYTES(NUM_BYTES)) u_props (.clk_sys, .rst_n,
   .hostWrEn, .hostRdEn, .fwWrEn, .fwRdEn, .hostAddr, .fwAddr, .fwWrData,
   .hostRdData_r, .fwRdData_r, .statusByte_r);
